//--- design/ura_core.sv
// Reset handling, register file and interrupt priority of the UART bridge
`timescale 1ns/1ps
`default_nettype none
module ura_core (
	input wire logic clock,
	input wire logic nrst,
	input wire logic reset_pin_n,
	input wire logic [4:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [7:0] rdata,
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	input wire logic rx_parity,
	input wire logic rx_framing,
	input wire logic rx_break,
	input wire logic rx_overrun,
	input wire logic rx_stop_mid,
	input wire logic char_tick,
	input wire logic xoff_seen,
	input wire logic xon_seen,
	input wire logic special_seen,
	output logic tx_valid,
	output logic [7:0] tx_data,
	input wire logic tx_take,
	input wire logic tx_shift_idle,
	input wire logic tx_serial,
	output logic tx_pin,
	output logic rts_n,
	input wire logic cts_n,
	input wire logic dsr_n,
	input wire logic ri_n,
	input wire logic cd_n,
	input wire logic [7:0] gpio_in,
	output logic [7:0] gpio_out,
	output logic [7:0] gpio_oe_n,
	output logic irq_out,
	output logic irq_oe_n,
	output logic uart_reset,
	output logic [15:0] divisor,
	output logic [7:0] line_format,
	output logic [7:0] enhanced_feature,
	output logic [31:0] flow_chars
);
	import ura_pkg::*;

	ura_state_s q;
	ura_state_s n;
	logic rst_any;
	logic [7:0] src;
	logic [5:0] code;
	logic [7:0] iir_val;
	logic [7:0] lsr_val;
	logic [7:0] msr_val;
	logic [6:0] rx_trig;
	logic [6:0] tx_trig;
	logic [6:0] tx_space;
	logic [10:0] rx_head;
	logic rx_below;

	function automatic logic [6:0] trig_sel(input logic [1:0] sel, input logic [3:0] tl,
		input logic [3:0][6:0] tbl);
		trig_sel = (tl != 4'h0) ? {1'b0, tl, 2'b00} : tbl[sel];
	endfunction

	function automatic logic [5:0] prio(input logic [7:0] s);
		if (s[0]) prio = C_LINE;
		else if (s[1]) prio = C_TMO;
		else if (s[2]) prio = C_RXD;
		else if (s[3]) prio = C_THR;
		else if (s[4]) prio = C_MDM;
		else if (s[5]) prio = C_GPIO;
		else if (s[6]) prio = C_XOFF;
		else if (s[7]) prio = C_HS;
		else prio = C_NONE;
	endfunction

	// All three sources share one path
	assign rst_any = !nrst || q.prst2 || q.ioctl[IOC_SWRST];
	assign uart_reset = rst_any;
	assign rx_head = q.rx_mem[q.rx_rp];
	assign tx_space = FIFO_DEPTH - q.tx_cnt;
	assign rx_trig = q.fifo_ctrl_reg[FCR_EN] ? trig_sel(q.fifo_ctrl_reg[7:6], q.trigger_level_reg[7:4], RX_TRIGS) : 7'h01;
	assign tx_trig = trig_sel(q.fifo_ctrl_reg[5:4], q.trigger_level_reg[3:0], TX_TRIGS);
	assign rx_below = q.rx_cnt < rx_trig;

	assign lsr_val[LSR_DR] = q.rx_cnt != 7'h00;
	assign lsr_val[LSR_OE] = q.ovr;
	assign lsr_val[4:2] = (q.rx_cnt != 7'h00) ? rx_head[E_BI:E_PE] : 3'h0;
	assign lsr_val[LSR_THRE] = q.tx_cnt == 7'h00;
	assign lsr_val[LSR_TEMT] = (q.tx_cnt == 7'h00) && tx_shift_idle;
	assign lsr_val[LSR_ERR] = q.err_cnt != 7'h00;
	assign msr_val = {~q.msync2, q.msr_chg};

	// Source vector, index 0 is the highest priority
	assign src[0] = q.irq_enable_reg[IER_LINE] && (lsr_val[LSR_ERR] || q.ovr);
	assign src[1] = q.irq_enable_reg[IER_RXD] && q.to_flag && rx_below && lsr_val[LSR_DR];
	assign src[2] = q.irq_enable_reg[IER_RXD] && !rx_below;
	assign src[3] = q.irq_enable_reg[IER_THR] && (q.fifo_ctrl_reg[FCR_EN] ? tx_space >= tx_trig
		: q.tx_cnt == 7'h00);
	assign src[4] = q.irq_enable_reg[IER_MDM] && (q.msr_chg != 4'h0);
	assign src[5] = q.gpio_chg != 8'h00;
	assign src[6] = q.irq_enable_reg[IER_XOFF] && (q.xoff || q.spec);
	assign src[7] = q.hs;
	assign code = prio(src);
	assign iir_val = {q.fifo_ctrl_reg[FCR_EN], q.fifo_ctrl_reg[FCR_EN], code};

	// Open drain: enable low pulls the line low
	assign irq_out = 1'b0;
	assign irq_oe_n = !(|src) || rst_any;
	assign tx_pin = rst_any || (tx_serial && !q.line_format_reg[LCR_BRK]);
	assign rts_n = !q.modem_ctrl_reg[MCR_RTS];
	assign gpio_oe_n = ~q.iodir;
	assign gpio_out = q.ioout;
	assign rdata = q.rdata;
	assign tx_valid = q.tx_cnt != 7'h00;
	assign tx_data = q.tx_mem[q.tx_rp];
	assign divisor = {q.divisor_high, q.dll};
	assign line_format = q.line_format_reg;
	assign enhanced_feature = q.enhanced_feature_reg;
	assign flow_chars = q.fchar;

	always_comb begin
		ura_state_s k;
		logic rd_iir;
		logic rx_push;
		logic rx_pop;
		logic tx_push;
		logic tx_pop;
		logic rx_err;
		k = '0;
		rd_iir = rd && addr == A_IIR;
		rx_push = rx_valid && q.rx_cnt != FIFO_DEPTH;
		rx_pop = rd && addr == A_HOLD && q.rx_cnt != 7'h00;
		tx_push = wr && addr == A_HOLD && q.tx_cnt != FIFO_DEPTH;
		tx_pop = tx_take && q.tx_cnt != 7'h00;
		rx_err = rx_parity || rx_framing || rx_break;
		n = q;
		n.rdata = 8'h00;
		n.prst1 = !reset_pin_n;
		n.prst2 = q.prst1;
		n.msync1 = {cd_n, ri_n, dsr_n, cts_n};
		n.msync2 = q.msync1;
		n.mprev = q.msync2;
		n.gsync1 = gpio_in;
		n.gsync2 = q.gsync1;
		n.gprev = q.gsync2;
		n.rts_prev = rts_n;
		// Sticky flags: the set term wins over a clear in the same cycle
		n.msr_chg = ((rd && addr == A_MSR) ? 4'h0 : q.msr_chg)
			| (q.msync2 ^ q.mprev);
		n.gpio_chg = ((rd && addr == A_IOSTATE) ? 8'h00 : q.gpio_chg)
			| ((q.gsync2 ^ q.gprev) & q.ioirq & ~q.iodir);
		n.ovr = (q.ovr && !(rd && addr == A_LSR)) || rx_overrun
			|| (rx_valid && !rx_push);
		n.xoff = (q.xoff && !xon_seen) || xoff_seen;
		n.spec = (q.spec && !rd_iir) || special_seen;
		n.hs = (q.hs && !rd_iir)
			|| (q.irq_enable_reg[IER_CTS] && q.msync2[0] && !q.mprev[0])
			|| (q.irq_enable_reg[IER_RTS] && rts_n && !q.rts_prev);
		if (wr) begin
			case (addr)
				A_IER: n.irq_enable_reg = wdata;
				A_IIR: n.fifo_ctrl_reg = wdata;
				A_LCR: n.line_format_reg = wdata;
				A_MCR: n.modem_ctrl_reg = wdata;
				A_SPR: n.scratch_reg = wdata;
				A_IODIR: n.iodir = wdata;
				A_IOSTATE: n.ioout = wdata;
				A_IOIRQ: n.ioirq = wdata;
				A_IOCTL: n.ioctl = wdata;
				A_EXTRA: n.extra = wdata;
				A_EFR: n.enhanced_feature_reg = wdata;
				A_TCR: n.flow_threshold_reg = wdata;
				A_TLR: n.trigger_level_reg = wdata;
				A_DLL: n.dll = wdata;
				A_DLH: n.divisor_high = wdata;
				A_FLOW_ON_CHAR_A: n.fchar[0] = wdata;
				A_FLOW_ON_CHAR_B: n.fchar[1] = wdata;
				A_FLOW_OFF_CHAR_A: n.fchar[2] = wdata;
				A_FLOW_OFF_CHAR_B: n.fchar[3] = wdata;
				default: n.irq_enable_reg = q.irq_enable_reg;
			endcase
		end
		if (rd) begin
			case (addr)
				A_HOLD: n.rdata = rx_head[7:0];
				A_IER: n.rdata = q.irq_enable_reg;
				A_IIR: n.rdata = iir_val;
				A_LCR: n.rdata = q.line_format_reg;
				A_MCR: n.rdata = q.modem_ctrl_reg;
				A_LSR: n.rdata = lsr_val;
				A_MSR: n.rdata = msr_val;
				A_SPR: n.rdata = q.scratch_reg;
				A_TXLVL: n.rdata = {1'b0, tx_space};
				A_RXLVL: n.rdata = {1'b0, q.rx_cnt};
				A_IODIR: n.rdata = q.iodir;
				A_IOSTATE: n.rdata = (q.gsync2 & ~q.iodir) | (q.ioout & q.iodir);
				A_IOIRQ: n.rdata = q.ioirq;
				A_IOCTL: n.rdata = q.ioctl;
				A_EXTRA: n.rdata = q.extra;
				A_EFR: n.rdata = q.enhanced_feature_reg;
				A_TCR: n.rdata = q.flow_threshold_reg;
				A_TLR: n.rdata = q.trigger_level_reg;
				A_DLL: n.rdata = q.dll;
				A_DLH: n.rdata = q.divisor_high;
				A_FLOW_ON_CHAR_A: n.rdata = q.fchar[0];
				A_FLOW_ON_CHAR_B: n.rdata = q.fchar[1];
				A_FLOW_OFF_CHAR_A: n.rdata = q.fchar[2];
				A_FLOW_OFF_CHAR_B: n.rdata = q.fchar[3];
				default: n.rdata = 8'h00;
			endcase
		end
		// Receive FIFO with per-entry error bits and error count
		if (rx_push) begin
			n.rx_mem[q.rx_wp] = {rx_break, rx_framing, rx_parity, rx_data};
			n.rx_wp = q.rx_wp + 6'h01;
		end
		if (rx_pop) begin
			n.rx_rp = q.rx_rp + 6'h01;
		end
		n.rx_cnt = q.rx_cnt + {6'h00, rx_push} - {6'h00, rx_pop};
		n.err_cnt = q.err_cnt + {6'h00, rx_push && rx_err}
			- {6'h00, rx_pop && (rx_head[E_BI:E_PE] != 3'h0)};
		// Transmit FIFO; a write while full is dropped
		if (tx_push) begin
			n.tx_mem[q.tx_wp] = wdata;
			n.tx_wp = q.tx_wp + 6'h01;
		end
		if (tx_pop) begin
			n.tx_rp = q.tx_rp + 6'h01;
		end
		n.tx_cnt = q.tx_cnt + {6'h00, tx_push} - {6'h00, tx_pop};
		// Character-time counter for stale receive data
		if (rx_stop_mid || rx_pop || q.rx_cnt == 7'h00) begin
			n.to_cnt = 3'h0;
			n.to_flag = 1'b0;
		end else if (char_tick && !q.to_flag) begin
			n.to_cnt = q.to_cnt + 3'h1;
			n.to_flag = (q.to_cnt + 3'h1) == TIMEOUT_CHARS;
		end
		if (rst_any) begin
			k = n;
			n = '0;
			n.line_format_reg = LCR_RST;
			n.dll = k.dll;
			n.divisor_high = k.divisor_high;
			n.scratch_reg = k.scratch_reg;
			n.fchar = k.fchar;
			if (nrst) begin
				n.prst1 = k.prst1;
				n.prst2 = k.prst2;
				n.msync1 = k.msync1;
				n.msync2 = k.msync2;
				n.mprev = k.msync2;
				n.gsync1 = k.gsync1;
				n.gsync2 = k.gsync2;
				n.gprev = k.gsync2;
				n.rts_prev = 1'b1;
			end else begin
				// Active-low modem pins idle high: no false change after release
				n.msync1 = '1;
				n.msync2 = '1;
				n.mprev = '1;
				n.rts_prev = 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		q <= n;
	end

	default clocking cb @(posedge clock); endclocking
	default disable iff (!nrst);

	sequence rst_seen;
		rst_any;
	endsequence

	sequence quiet_bus;
		!wr && !rd;
	endsequence

	sequence iir_read;
		rd && addr == A_IIR;
	endsequence

	iir_reset_a: assert property (rst_seen |=> iir_val == {2'b00, C_NONE})
		else $error("identity not idle after reset");
	lcr_reset_a: assert property (rst_seen |=> q.line_format_reg == LCR_RST)
		else $error("line format reset value wrong");
	lsr_reset_a: assert property (rst_seen |=> lsr_val[LSR_THRE] && lsr_val[4:0] == 5'h00
		&& !lsr_val[LSR_ERR])
		else $error("line status reset value wrong");
	msr_reset_a: assert property (rst_seen |=> msr_val[3:0] == 4'h0)
		else $error("modem change bits survive reset");
	lvl_reset_a: assert property (rst_seen |=> tx_space == FIFO_DEPTH && q.rx_cnt == 7'h00)
		else $error("fifo levels wrong after reset");
	keep_div_a: assert property (rst_seen ##0 quiet_bus |=> q.dll == $past(q.dll)
		&& q.fchar == $past(q.fchar))
		else $error("kept register changed by reset");
	irq_track_a: assert property (iir_val[0] == irq_oe_n || rst_any)
		else $error("interrupt pin disagrees with identity");
	line_prio_a: assert property (q.irq_enable_reg[IER_LINE] && lsr_val[LSR_ERR] |-> code == C_LINE)
		else $error("line status not top priority");
	empty_err_a: assert property (q.rx_cnt == 7'h00 |-> lsr_val[4:2] == 3'h0)
		else $error("error bits set with empty fifo");
	tmo_count_a: assert property ($rose(q.to_flag) |-> $past(q.to_cnt) == TIMEOUT_CHARS - 3'h1
		&& $past(char_tick))
		else $error("time-out fired at wrong count");
	xon_clear_a: assert property (xon_seen && !xoff_seen && !rst_any |=> !q.xoff)
		else $error("flow-on did not clear flow-off");
	sum_err_a: assert property (lsr_val[LSR_ERR] |-> lsr_val[LSR_DR] && q.err_cnt <= q.rx_cnt)
		else $error("error summary without erroneous entry");

	// Reset state, sources and priority order
	ctl_clear_a: assert property (rst_seen |=> {q.irq_enable_reg, q.fifo_ctrl_reg, q.modem_ctrl_reg, q.enhanced_feature_reg} == '0
		&& {q.flow_threshold_reg, q.trigger_level_reg, q.iodir, q.ioirq, q.ioctl, q.extra} == '0
		&& {q.rx_wp, q.rx_rp, q.tx_wp, q.tx_rp} == '0)
		else $error("control state survived reset");
	rst_pins_a: assert property (rst_seen |=> rts_n && irq_oe_n && gpio_oe_n == 8'hFF)
		else $error("outputs not idle after reset");
	tmo_prio_a: assert property (src[1] && !src[0] |-> code == C_TMO)
		else $error("time-out code wrong");
	rxd_src_a: assert property (q.irq_enable_reg[IER_RXD] && !q.fifo_ctrl_reg[FCR_EN]
		&& lsr_val[LSR_DR] |-> src[2])
		else $error("ready character raised no receive interrupt");
	thr_src_a: assert property (q.irq_enable_reg[IER_THR] && !q.fifo_ctrl_reg[FCR_EN]
		|-> src[3] == lsr_val[LSR_THRE])
		else $error("holding area state and interrupt differ");
	mdm_prio_a: assert property (src[4] && src[3:0] == 4'h0 |-> code == C_MDM)
		else $error("modem change code wrong");
	gpio_prio_a: assert property (src[5] && src[4:0] == 5'h00 |-> code == C_GPIO)
		else $error("pin change code wrong");
	hs_prio_a: assert property (src[7] && src[6:0] == 7'h00 |-> code == C_HS)
		else $error("handshake code wrong");
	xoff_set_a: assert property (q.irq_enable_reg[IER_XOFF] && special_seen && !wr && !rst_any
		|=> src[6])
		else $error("special character raised no interrupt");
	spec_clear_a: assert property (q.spec && !special_seen && !rst_any ##0 iir_read
		|=> !q.spec)
		else $error("special flag kept after identity read");
	tmo_restart_a: assert property (rx_stop_mid |=> q.to_cnt == 3'h0 && !q.to_flag)
		else $error("time-out counter not restarted");
endmodule
`default_nettype wire

//--- design/ura_pkg.sv
// Constants and state type for the reset and interrupt priority block
package ura_pkg;
	localparam int PTR_W = 6;
	localparam logic [6:0] FIFO_DEPTH = 7'h40;
	localparam logic [2:0] TIMEOUT_CHARS = 3'h4;
	localparam logic [7:0] LCR_RST = 8'h1D;
	// Register indices
	localparam logic [4:0] A_HOLD = 5'h00;
	localparam logic [4:0] A_IER = 5'h01;
	localparam logic [4:0] A_IIR = 5'h02;
	localparam logic [4:0] A_LCR = 5'h03;
	localparam logic [4:0] A_MCR = 5'h04;
	localparam logic [4:0] A_LSR = 5'h05;
	localparam logic [4:0] A_MSR = 5'h06;
	localparam logic [4:0] A_SPR = 5'h07;
	localparam logic [4:0] A_TXLVL = 5'h08;
	localparam logic [4:0] A_RXLVL = 5'h09;
	localparam logic [4:0] A_IODIR = 5'h0A;
	localparam logic [4:0] A_IOSTATE = 5'h0B;
	localparam logic [4:0] A_IOIRQ = 5'h0C;
	localparam logic [4:0] A_IOCTL = 5'h0D;
	localparam logic [4:0] A_EXTRA = 5'h0E;
	localparam logic [4:0] A_EFR = 5'h0F;
	localparam logic [4:0] A_TCR = 5'h10;
	localparam logic [4:0] A_TLR = 5'h11;
	localparam logic [4:0] A_DLL = 5'h12;
	localparam logic [4:0] A_DLH = 5'h13;
	localparam logic [4:0] A_FLOW_ON_CHAR_A = 5'h14;
	localparam logic [4:0] A_FLOW_ON_CHAR_B = 5'h15;
	localparam logic [4:0] A_FLOW_OFF_CHAR_A = 5'h16;
	localparam logic [4:0] A_FLOW_OFF_CHAR_B = 5'h17;
	// Identification codes
	localparam logic [5:0] C_NONE = 6'h01;
	localparam logic [5:0] C_LINE = 6'h06;
	localparam logic [5:0] C_TMO = 6'h0C;
	localparam logic [5:0] C_RXD = 6'h04;
	localparam logic [5:0] C_THR = 6'h02;
	localparam logic [5:0] C_MDM = 6'h00;
	localparam logic [5:0] C_GPIO = 6'h30;
	localparam logic [5:0] C_XOFF = 6'h10;
	localparam logic [5:0] C_HS = 6'h20;
	// Field positions
	localparam int IER_RXD = 0;
	localparam int IER_THR = 1;
	localparam int IER_LINE = 2;
	localparam int IER_MDM = 3;
	localparam int IER_XOFF = 5;
	localparam int IER_RTS = 6;
	localparam int IER_CTS = 7;
	localparam int FCR_EN = 0;
	localparam int LCR_BRK = 6;
	localparam int MCR_RTS = 1;
	localparam int IOC_SWRST = 3;
	localparam int LSR_DR = 0;
	localparam int LSR_OE = 1;
	localparam int LSR_THRE = 5;
	localparam int LSR_TEMT = 6;
	localparam int LSR_ERR = 7;
	localparam int E_PE = 8;
	localparam int E_FE = 9;
	localparam int E_BI = 10;
	// Selectable trigger levels, indexed by the two select bits
	localparam logic [3:0][6:0] RX_TRIGS = {7'h3C, 7'h38, 7'h10, 7'h08};
	localparam logic [3:0][6:0] TX_TRIGS = {7'h38, 7'h20, 7'h10, 7'h08};

	typedef struct packed {
		logic prst1;
		logic prst2;
		logic [3:0] msync1;
		logic [3:0] msync2;
		logic [3:0] mprev;
		logic [7:0] gsync1;
		logic [7:0] gsync2;
		logic [7:0] gprev;
		logic rts_prev;
		logic [7:0] irq_enable_reg;
		logic [7:0] fifo_ctrl_reg;
		logic [7:0] line_format_reg;
		logic [7:0] modem_ctrl_reg;
		logic [7:0] enhanced_feature_reg;
		logic [7:0] flow_threshold_reg;
		logic [7:0] trigger_level_reg;
		logic [7:0] iodir;
		logic [7:0] ioirq;
		logic [7:0] ioctl;
		logic [7:0] extra;
		logic [7:0] ioout;
		logic [7:0] dll;
		logic [7:0] divisor_high;
		logic [7:0] scratch_reg;
		logic [3:0][7:0] fchar;
		logic [3:0] msr_chg;
		logic [7:0] gpio_chg;
		logic ovr;
		logic xoff;
		logic spec;
		logic hs;
		logic [63:0][10:0] rx_mem;
		logic [PTR_W-1:0] rx_wp;
		logic [PTR_W-1:0] rx_rp;
		logic [6:0] rx_cnt;
		logic [6:0] err_cnt;
		logic [63:0][7:0] tx_mem;
		logic [PTR_W-1:0] tx_wp;
		logic [PTR_W-1:0] tx_rp;
		logic [6:0] tx_cnt;
		logic [2:0] to_cnt;
		logic to_flag;
		logic [7:0] rdata;
	} ura_state_s;
endpackage

//--- verification/ura_host_model.sv
// Host processor model driving the register port
`timescale 1ns/1ps
`default_nettype none
module ura_host_model (
	input wire logic clock,
	output logic [4:0] addr,
	output logic [7:0] wdata,
	output logic wr,
	output logic rd,
	input wire logic [7:0] rdata
);
	logic busy = 1'b0;
	initial begin
		addr = 5'h15;
		wdata = 8'hA5;
		wr = 1'b0;
		rd = 1'b0;
	end
	// Idle lines toggle so stale values never pass
	always @(posedge clock) begin
		if (!busy) begin
			addr <= ~addr;
			wdata <= ~wdata;
		end
	end
	task automatic start(input logic [4:0] a);
		while ($time < 3000) @(posedge clock);
		busy = 1'b1;
		@(posedge clock);
		addr <= a;
	endtask
	task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
		start(a);
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
		busy = 1'b0;
	endtask
	task automatic rd_reg(input logic [4:0] a, output logic [7:0] d);
		start(a);
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1;
		d = rdata;
		busy = 1'b0;
	endtask
endmodule
`default_nettype wire

//--- verification/testbench.sv
// Self-checking bench for the reset and interrupt priority block
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import ura_pkg::*;
	localparam logic [4:0] RA[16] = '{A_IER, A_IIR, A_LCR, A_MCR, A_LSR, A_MSR, A_TXLVL, A_RXLVL,
		A_IODIR, A_IOIRQ, A_IOCTL, A_EXTRA, A_EFR, A_TCR, A_TLR, 5'h1F};
	localparam logic [7:0] RV[16] = '{8'h00, 8'h01, 8'h1D, 8'h00, 8'h60, 8'h00, 8'h40, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [4:0] RT[7] = '{A_DLL, A_DLH, A_SPR, A_FLOW_ON_CHAR_A, A_FLOW_ON_CHAR_B, A_FLOW_OFF_CHAR_A, A_FLOW_OFF_CHAR_B};
	localparam logic [4:0] CL[12] = '{A_IER, A_IIR, A_LCR, A_MCR, A_IODIR, A_IOIRQ, A_IOCTL,
		A_EXTRA, A_EFR, A_TCR, A_TLR, 5'h1F};
	logic clock = 1'b0;
	logic nrst = 1'b0;
	logic reset_pin_n = 1'b1;
	logic rx_valid = 1'b0;
	logic cts_n = 1'b1;
	logic shift_idle = 1'b1;
	logic [7:0] line_format, enhanced_feature, gpio_out;
	logic irq_out, uart_reset;
	logic fe = 1'b0;
	logic [2:0] rx_err = 3'h0;
	logic [6:0] pv = 7'h00;
	logic [7:0] rx_data = 8'h00;
	logic [7:0] gpio_in = 8'h00;
	logic [4:0] addr;
	logic [7:0] wdata, rdata, tx_data, gpio_oe_n, v;
	logic wr, rd, tx_valid, tx_pin, rts_n, irq_oe_n;
	logic [15:0] divisor;
	logic [31:0] flow_chars;
	logic [7:0] keep[7];
	logic [10:0] q[$];
	int seed = 4129;
	int miscompares = 0;
	int num_checks = 0;
	int cyc = 0;
	always #12.5 clock = ~clock;
	ura_core dut_u (.clock(clock), .nrst(nrst), .reset_pin_n(reset_pin_n), .addr(addr),
		.wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .rx_valid(rx_valid), .rx_data(rx_data),
		.rx_parity(rx_err[0]), .rx_framing(rx_err[1]), .rx_break(rx_err[2]),
		.rx_overrun(pv[6]), .rx_stop_mid(pv[2]), .char_tick(pv[1]), .xoff_seen(pv[3]),
		.xon_seen(pv[4]), .special_seen(pv[5]), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_take(pv[0]), .tx_shift_idle(shift_idle), .tx_serial(1'b1), .tx_pin(tx_pin),
		.rts_n(rts_n), .cts_n(cts_n), .dsr_n(cts_n), .ri_n(1'b1), .cd_n(1'b1), .gpio_in(gpio_in),
		.gpio_out(gpio_out), .gpio_oe_n(gpio_oe_n), .irq_out(irq_out), .irq_oe_n(irq_oe_n),
		.uart_reset(uart_reset), .divisor(divisor), .line_format(line_format),
		.enhanced_feature(enhanced_feature), .flow_chars(flow_chars));
	ura_host_model host_u (.clock(clock), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata));
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			miscompares++;
			print_verdict();
		end
	end
	// Receive model: expected line status from queued entries
	function automatic logic [7:0] exp_lsr();
		logic [7:0] e;
		e = {1'b0, shift_idle, 6'h20};
		if (q.size() > 0) begin
			e[0] = 1'b1;
			e[4:2] = q[0][10:8];
		end
		foreach (q[i]) e[7] |= (q[i][10:8] != 3'h0);
		return e;
	endfunction
	task automatic pulse(input int k);
		@(posedge clock);
		pv[k] <= 1'b1;
		@(posedge clock);
		pv <= 7'h00;
	endtask
	task automatic pins(input logic c, input logic [7:0] g);
		@(posedge clock);
		cts_n <= c;
		gpio_in <= g;
	endtask
	task automatic push(input logic [2:0] e);
		@(posedge clock);
		rx_valid <= 1'b1;
		rx_data <= 8'($random(seed));
		rx_err <= e;
		@(posedge clock);
		rx_valid <= 1'b0;
		q.push_back({rx_err, rx_data});
	endtask
	task automatic lsr_chk();
		host_u.rd_reg(A_LSR, v);
		chk(v, exp_lsr());
	endtask
	task automatic pop_chk();
		host_u.rd_reg(A_HOLD, v);
		chk(v, q[0][7:0]);
		void'(q.pop_front());
	endtask
	task automatic chk_id(input logic [5:0] code);
		repeat (6) @(posedge clock);
		#1;
		chk(irq_oe_n, code[0]);
		host_u.rd_reg(A_IIR, v);
		chk(v, {fe, fe, code});
	endtask
	task automatic do_reset(input int k);
		@(posedge clock);
		if (k == 0) nrst <= 1'b0;
		if (k == 1) reset_pin_n <= 1'b0;
		if (k == 2) host_u.wr_reg(A_IOCTL, 8'h08);
		else repeat (3) @(posedge clock);
		#1;
		chk({uart_reset, irq_oe_n, tx_pin}, 3'h7);
		@(posedge clock);
		nrst <= 1'b1;
		reset_pin_n <= 1'b1;
		repeat (3) @(posedge clock);
	endtask
	initial begin
		repeat (16) @(posedge clock);
		nrst <= 1'b1;
		for (int k = 0; k < 3; k++) begin
			foreach (keep[i]) begin
				keep[i] = 8'($random(seed));
				host_u.wr_reg(RT[i], keep[i]);
			end
			foreach (CL[i]) host_u.wr_reg(CL[i], 8'($random(seed)) & 8'hF7);
			do_reset(k);
			foreach (RA[i]) begin
				host_u.rd_reg(RA[i], v);
				chk(v, RV[i]);
			end
			foreach (RT[i]) begin
				host_u.rd_reg(RT[i], v);
				chk(v, keep[i]);
			end
			chk({divisor, flow_chars}, {keep[1], keep[0], keep[6], keep[5], keep[4], keep[3]});
			chk({tx_pin, rts_n, irq_oe_n, gpio_oe_n}, 11'h7FF);
			chk({line_format, enhanced_feature}, 16'h1D00);
			chk({gpio_out, irq_out, uart_reset}, 10'h000);
			$display("test reset %0d finished", k);
		end
		chk_id(6'h01);
		host_u.wr_reg(A_IER, 8'h02);
		chk_id(6'h02);
		host_u.wr_reg(A_HOLD, 8'h5A);
		chk_id(6'h01);
		chk({tx_valid, tx_data}, 9'h15A);
		pulse(0);
		chk_id(6'h02);
		$display("test thr finished");
		host_u.wr_reg(A_IER, 8'h05);
		push(3'h0);
		chk_id(6'h04);
		push(3'h2);
		chk_id(6'h06);
		lsr_chk();
		pop_chk();
		lsr_chk();
		chk_id(6'h06);
		pop_chk();
		lsr_chk();
		for (int i = 0; i < 3; i++) begin
			push(3'(1 << i));
			lsr_chk();
			pop_chk();
		end
		pulse(6);
		chk_id(6'h06);
		host_u.rd_reg(A_LSR, v);
		chk(v, 8'h62);
		chk_id(6'h01);
		@(posedge clock);
		shift_idle <= 1'b0;
		lsr_chk();
		@(posedge clock);
		shift_idle <= 1'b1;
		$display("test rx finished");
		host_u.wr_reg(A_IIR, 8'h01);
		fe = 1'b1;
		host_u.wr_reg(A_IER, 8'h01);
		push(3'h0);
		repeat (3) pulse(1);
		pulse(2);
		repeat (3) pulse(1);
		chk_id(6'h01);
		pulse(1);
		chk_id(6'h0C);
		pop_chk();
		chk_id(6'h01);
		host_u.wr_reg(A_IIR, 8'h00);
		fe = 1'b0;
		$display("test timeout finished");
		host_u.wr_reg(A_IER, 8'h08);
		pins(1'b0, gpio_in);
		chk_id(6'h00);
		host_u.rd_reg(A_MSR, v);
		chk(v, 8'h33);
		chk_id(6'h01);
		host_u.wr_reg(A_IOIRQ, 8'hFF);
		host_u.wr_reg(A_IER, 8'h00);
		pins(1'b0, gpio_in ^ (8'($random(seed)) | 8'h01));
		chk_id(6'h30);
		host_u.rd_reg(A_IOSTATE, v);
		chk(v, gpio_in);
		chk_id(6'h01);
		host_u.wr_reg(A_IOIRQ, 8'h00);
		host_u.wr_reg(A_IER, 8'h20);
		pulse(3);
		chk_id(6'h10);
		chk_id(6'h10);
		pulse(4);
		chk_id(6'h01);
		pulse(5);
		chk_id(6'h10);
		chk_id(6'h01);
		host_u.wr_reg(A_IER, 8'h80);
		pins(1'b1, gpio_in);
		chk_id(6'h20);
		chk_id(6'h01);
		host_u.wr_reg(A_IER, 8'h2A);
		pulse(3);
		pins(1'b0, gpio_in);
		chk_id(6'h02);
		host_u.wr_reg(A_IER, 8'h28);
		chk_id(6'h00);
		host_u.rd_reg(A_MSR, v);
		chk_id(6'h10);
		pulse(4);
		chk_id(6'h01);
		$display("test irq finished");
		print_verdict();
	end
endmodule
`default_nettype wire
